// ### design/pts_path_trigger.sv
// Path trigger register, event dispatch, retention control and soft limits
`timescale 1ns/1ps
module pts_path_trigger #(
   parameter int POS_W = 32,
   parameter int EV_N = 4
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic par_wr_i,
   input wire logic par_rd_i,
   input wire logic [6:0] par_addr_i,
   input wire logic [31:0] par_wdata_i,
   output logic [31:0] par_rdata_o,
   output logic par_ack_o,
   output logic par_err_o,
   input wire logic [EV_N-1:0] event_input_i,
   input wire logic cmd_issued_i,
   input wire logic motion_done_i,
   input wire logic target_reached_output_i,
   input wire logic path_mode_i,
   input wire logic [POS_W-1:0] feedback_pos_i,
   input wire logic alarm_clear_i,
   output logic home_start_o,
   output logic path_start_o,
   output logic [5:0] path_num_o,
   output logic stop_o,
   output logic path1_volatile_o,
   output logic path2_volatile_o,
   output logic forward_overtravel_alarm_o,
   output logic reverse_overtravel_alarm_o
);
   // Elaboration check, the logic is written for these sizes only
   if (POS_W != 32 || EV_N != 4)
   begin
      $error("pts_path_trigger serves POS_W 32 and EV_N 4 only");
   end

   function automatic logic sgt(input logic [31:0] a, input logic [31:0] b);
      sgt = $signed(a) > $signed(b);
   endfunction

   function automatic logic sel_ok(input logic [15:0] v);
      sel_ok = (v[3:0] <= pts_pkg::PTS_EV_FIELD_MAX) && (v[7:4] <= pts_pkg::PTS_EV_FIELD_MAX)
         && (v[11:8] <= pts_pkg::PTS_EV_FIELD_MAX) && (v[15:12] <= pts_pkg::PTS_EV_FIELD_MAX);
   endfunction

   logic [15:0] cmd_reg, cmd_next;
   pts_pkg::pts_phase_type ph_reg, ph_next;
   logic [15:0] rise_reg, rise_next;
   logic [15:0] fall_reg, fall_next;
   logic [15:0] ret_reg, ret_next;
   logic [31:0] fwd_reg, fwd_next;
   logic [31:0] rev_reg, rev_next;
   logic [3:0] ev_prev_reg, ev_prev_next;
   logic [3:0] pend_reg, pend_next;
   logic [5:0] pend_path_reg [4];
   logic [5:0] pend_path_next [4];
   logic [31:0] pos_prev_reg, pos_prev_next;
   logic fwd_alm_reg, fwd_alm_next;
   logic rev_alm_reg, rev_alm_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   logic err_reg, err_next;
   logic home_reg, home_next;
   logic pstart_reg, pstart_next;
   logic [5:0] pnum_reg, pnum_next;
   logic stop_reg, stop_next;

   logic wr_trig, trig_ok, host_trig;
   logic [3:0] ev_rise, ev_fall;
   logic fwd_hit, rev_hit;

   assign wr_trig = par_wr_i && (par_addr_i == pts_pkg::PTS_IDX_TRIG);
   assign trig_ok = (par_wdata_i[31:16] == 16'h0000)
      && ((par_wdata_i[15:0] <= pts_pkg::PTS_CMD_PATH_MAX)
      || (par_wdata_i[15:0] == pts_pkg::PTS_CMD_STOP));
   assign host_trig = wr_trig && trig_ok;
   assign ev_rise = event_input_i & ~ev_prev_reg;
   assign ev_fall = ~event_input_i & ev_prev_reg;
   assign fwd_hit = path_mode_i && sgt(feedback_pos_i, pos_prev_reg)
      && sgt(feedback_pos_i, fwd_reg);
   assign rev_hit = path_mode_i && sgt(pos_prev_reg, feedback_pos_i)
      && sgt(rev_reg, feedback_pos_i);

   always_comb
   begin
      logic [3:0] fld;
      logic found;
      fld = 4'h0;
      found = 1'b0;
      cmd_next = cmd_reg;
      ph_next = ph_reg;
      rise_next = rise_reg;
      fall_next = fall_reg;
      ret_next = ret_reg;
      fwd_next = fwd_reg;
      rev_next = rev_reg;
      ev_prev_next = event_input_i;
      pend_next = pend_reg;
      pend_path_next = pend_path_reg;
      pos_prev_next = feedback_pos_i;
      rdata_next = rdata_reg;
      ack_next = par_wr_i || par_rd_i;
      err_next = 1'b0;
      home_next = 1'b0;
      pstart_next = 1'b0;
      pnum_next = pnum_reg;
      stop_next = 1'b0;
      // Command progress
      case (ph_reg)
         pts_pkg::PTS_PH_ISSUE:
         begin
            if (cmd_issued_i)
            begin
               ph_next = pts_pkg::PTS_PH_MOVE;
            end
         end
         pts_pkg::PTS_PH_MOVE:
         begin
            if (target_reached_output_i && motion_done_i)
            begin
               ph_next = pts_pkg::PTS_PH_REACH;
            end
         end
         default:
         begin
            ph_next = ph_reg;
         end
      endcase
      // Dispatch of one pending event launch, host trigger takes precedence
      for (int i = 0; i < 4; i++)
      begin
         if (!host_trig && !found && pend_reg[i])
         begin
            found = 1'b1;
            pend_next[i] = 1'b0;
            pstart_next = 1'b1;
            pnum_next = pend_path_reg[i];
            cmd_next = {10'h000, pend_path_reg[i]};
            ph_next = pts_pkg::PTS_PH_ISSUE;
         end
      end
      // Edge capture, a new launch overrides the clear of its slot
      for (int i = 0; i < 4; i++)
      begin
         fld = 4'h0;
         if (ev_rise[i])
         begin
            fld = rise_reg[4*i +: 4];
         end
         else if (ev_fall[i])
         begin
            fld = fall_reg[4*i +: 4];
         end
         if (fld != 4'h0)
         begin
            pend_next[i] = 1'b1;
            pend_path_next[i] = pts_pkg::PTS_EV_PATH_BASE + {2'b00, fld};
         end
      end
      // Host trigger
      if (host_trig)
      begin
         cmd_next = par_wdata_i[15:0];
         ph_next = pts_pkg::PTS_PH_ISSUE;
         if (par_wdata_i[15:0] == pts_pkg::PTS_CMD_HOME)
         begin
            home_next = 1'b1;
         end
         else if (par_wdata_i[15:0] == pts_pkg::PTS_CMD_STOP)
         begin
            stop_next = 1'b1;
         end
         else
         begin
            pstart_next = 1'b1;
            pnum_next = par_wdata_i[5:0];
         end
      end
      // Parameter writes
      if (par_wr_i)
      begin
         if (par_addr_i == pts_pkg::PTS_IDX_TRIG)
         begin
            err_next = !trig_ok;
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_RISE)
         begin
            if (par_wdata_i[31:16] == 16'h0000 && sel_ok(par_wdata_i[15:0]))
            begin
               rise_next = par_wdata_i[15:0];
            end
            else
            begin
               err_next = 1'b1;
            end
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_FALL)
         begin
            if (par_wdata_i[31:16] == 16'h0000 && sel_ok(par_wdata_i[15:0]))
            begin
               fall_next = par_wdata_i[15:0];
            end
            else
            begin
               err_next = 1'b1;
            end
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_RET)
         begin
            ret_next = par_wdata_i[15:0] & pts_pkg::PTS_RET_MASK;
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_FWD)
         begin
            if (par_wdata_i != pts_pkg::PTS_POS_FORBID)
            begin
               fwd_next = par_wdata_i;
            end
            else
            begin
               err_next = 1'b1;
            end
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_REV)
         begin
            if (par_wdata_i != pts_pkg::PTS_POS_FORBID)
            begin
               rev_next = par_wdata_i;
            end
            else
            begin
               err_next = 1'b1;
            end
         end
         else
         begin
            err_next = 1'b1;
         end
      end
      // Parameter reads
      if (par_rd_i)
      begin
         if (par_addr_i == pts_pkg::PTS_IDX_TRIG)
         begin
            case (ph_reg)
               pts_pkg::PTS_PH_MOVE:
               begin
                  rdata_next = {16'h0000, cmd_reg + pts_pkg::PTS_ISSUED_OFS};
               end
               pts_pkg::PTS_PH_REACH:
               begin
                  rdata_next = {16'h0000, cmd_reg + pts_pkg::PTS_REACHED_OFS};
               end
               default:
               begin
                  rdata_next = {16'h0000, cmd_reg};
               end
            endcase
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_RISE)
         begin
            rdata_next = {16'h0000, rise_reg};
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_FALL)
         begin
            rdata_next = {16'h0000, fall_reg};
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_RET)
         begin
            rdata_next = {16'h0000, ret_reg};
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_FWD)
         begin
            rdata_next = fwd_reg;
         end
         else if (par_addr_i == pts_pkg::PTS_IDX_REV)
         begin
            rdata_next = rev_reg;
         end
         else
         begin
            rdata_next = 32'h00000000;
            err_next = 1'b1;
         end
      end
      // Sticky alarms, a new hit wins over the clear
      fwd_alm_next = fwd_hit || (fwd_alm_reg && !alarm_clear_i);
      rev_alm_next = rev_hit || (rev_alm_reg && !alarm_clear_i);
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         cmd_reg <= pts_pkg::PTS_TRIG_RST;
         ph_reg <= pts_pkg::PTS_PH_IDLE;
         rise_reg <= pts_pkg::PTS_RISE_RST;
         fall_reg <= pts_pkg::PTS_FALL_RST;
         ret_reg <= pts_pkg::PTS_RET_RST;
         fwd_reg <= pts_pkg::PTS_FWD_RST;
         rev_reg <= pts_pkg::PTS_REV_RST;
         ev_prev_reg <= 4'h0;
         pend_reg <= 4'h0;
         pend_path_reg <= '{default: 6'h00};
         pos_prev_reg <= 32'h00000000;
         fwd_alm_reg <= 1'b0;
         rev_alm_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         home_reg <= 1'b0;
         pstart_reg <= 1'b0;
         pnum_reg <= 6'h00;
         stop_reg <= 1'b0;
      end
      else
      begin
         cmd_reg <= cmd_next;
         ph_reg <= ph_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         ret_reg <= ret_next;
         fwd_reg <= fwd_next;
         rev_reg <= rev_next;
         ev_prev_reg <= ev_prev_next;
         pend_reg <= pend_next;
         pend_path_reg <= pend_path_next;
         pos_prev_reg <= pos_prev_next;
         fwd_alm_reg <= fwd_alm_next;
         rev_alm_reg <= rev_alm_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         home_reg <= home_next;
         pstart_reg <= pstart_next;
         pnum_reg <= pnum_next;
         stop_reg <= stop_next;
      end
   end

   assign par_rdata_o = rdata_reg;
   assign par_ack_o = ack_reg;
   assign par_err_o = err_reg;
   assign home_start_o = home_reg;
   assign path_start_o = pstart_reg;
   assign path_num_o = pnum_reg;
   assign stop_o = stop_reg;
   assign path1_volatile_o = ret_reg[pts_pkg::PTS_RET_P1_BIT];
   assign path2_volatile_o = ret_reg[pts_pkg::PTS_RET_P2_BIT];
   assign forward_overtravel_alarm_o = fwd_alm_reg;
   assign reverse_overtravel_alarm_o = rev_alm_reg;

   AST_HOME: assert property (@(posedge mclk_i) disable iff (srst_i)
      host_trig && par_wdata_i[15:0] == 16'h0000 |=> home_start_o && !path_start_o)
      else $error("homing not started");
   AST_PATH: assert property (@(posedge mclk_i) disable iff (srst_i)
      host_trig && par_wdata_i[15:0] != 16'h0000 && par_wdata_i[15:0] <= 16'h003F
      |=> path_start_o && path_num_o == $past(par_wdata_i[5:0]))
      else $error("path not started with written number");
   AST_REFUSE: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr_trig && par_wdata_i >= 32'h00000040 && par_wdata_i <= 32'h0000270F
      && par_wdata_i != 32'h000003E8 && !pend_reg[0] && !pend_reg[1] && !pend_reg[2]
      && !pend_reg[3] |=> par_err_o && $stable(cmd_reg) && !path_start_o)
      else $error("out of range trigger not refused");
   AST_STOP: assert property (@(posedge mclk_i) disable iff (srst_i)
      host_trig && par_wdata_i[15:0] == 16'h03E8 |=> stop_o && cmd_reg == 16'h03E8)
      else $error("stop not issued");
   AST_RD_ISSUE: assert property (@(posedge mclk_i) disable iff (srst_i)
      par_rd_i && par_addr_i == pts_pkg::PTS_IDX_TRIG && ph_reg == pts_pkg::PTS_PH_ISSUE
      |=> par_rdata_o == {16'h0000, $past(cmd_reg)})
      else $error("issuing read not original command");
   AST_RD_MOVE: assert property (@(posedge mclk_i) disable iff (srst_i)
      par_rd_i && par_addr_i == pts_pkg::PTS_IDX_TRIG && ph_reg == pts_pkg::PTS_PH_MOVE
      |=> par_rdata_o == 32'h00002710 + {16'h0000, $past(cmd_reg)})
      else $error("moving read not plus 10000");
   AST_RD_REACH: assert property (@(posedge mclk_i) disable iff (srst_i)
      ph_reg == pts_pkg::PTS_PH_MOVE && target_reached_output_i && motion_done_i
      && !host_trig && pend_reg == 4'h0 && par_rd_i == 1'b0
      ##1 par_rd_i && par_addr_i == pts_pkg::PTS_IDX_TRIG
      |=> par_rdata_o == 32'h00004E20 + {16'h0000, $past(cmd_reg)})
      else $error("reached read not plus 20000");
   AST_EV_NONE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ev_rise[1] && rise_reg[7:4] == 4'h0 && pend_reg == 4'h0 && !host_trig
      |=> !path_start_o ##1 !path_start_o)
      else $error("zero field launched a path");
   AST_EV_RUN: assert property (@(posedge mclk_i) disable iff (srst_i)
      ev_rise[2] && rise_reg[11:8] != 4'h0 && pend_reg == 4'h0 && !host_trig && !wr_trig
      ##1 !host_trig |=> path_start_o && path_num_o == 6'h32 + {2'b00, $past(rise_reg[11:8], 2)})
      else $error("rising event path wrong");
   AST_EV_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
      ev_fall[3] && fall_reg[15:12] != 4'h0 && pend_reg == 4'h0 && !host_trig && !wr_trig
      ##1 !host_trig |=> path_start_o && path_num_o == 6'h32 + {2'b00, $past(fall_reg[15:12], 2)})
      else $error("falling event path wrong");
   AST_FWD: assert property (@(posedge mclk_i) disable iff (srst_i)
      path_mode_i && $signed(feedback_pos_i) > $signed(pos_prev_reg)
      && $signed(feedback_pos_i) > $signed(fwd_reg) |=> forward_overtravel_alarm_o)
      else $error("forward alarm missing");
   AST_REV: assert property (@(posedge mclk_i) disable iff (srst_i)
      !path_mode_i && !reverse_overtravel_alarm_o |=> !reverse_overtravel_alarm_o)
      else $error("reverse alarm outside path mode");
endmodule

// ### design/pts_pkg.sv
// Constants and types for the path trigger and soft limit block
package pts_pkg;
   localparam logic [6:0] PTS_IDX_TRIG = 7'h52;
   localparam logic [6:0] PTS_IDX_RISE = 7'h53;
   localparam logic [6:0] PTS_IDX_FALL = 7'h54;
   localparam logic [6:0] PTS_IDX_RET = 7'h55;
   localparam logic [6:0] PTS_IDX_FWD = 7'h56;
   localparam logic [6:0] PTS_IDX_REV = 7'h57;
   localparam logic [15:0] PTS_CMD_HOME = 16'h0000;
   localparam logic [15:0] PTS_CMD_PATH_MAX = 16'h003F;
   localparam logic [15:0] PTS_CMD_STOP = 16'h03E8;
   localparam logic [15:0] PTS_CMD_BAD_MAX = 16'h270F;
   localparam logic [15:0] PTS_ISSUED_OFS = 16'h2710;
   localparam logic [15:0] PTS_REACHED_OFS = 16'h4E20;
   localparam logic [3:0] PTS_EV_FIELD_MAX = 4'hD;
   localparam logic [5:0] PTS_EV_PATH_BASE = 6'h32;
   localparam logic [15:0] PTS_RET_MASK = 16'h0011;
   localparam int PTS_RET_P1_BIT = 0;
   localparam int PTS_RET_P2_BIT = 4;
   localparam logic [15:0] PTS_TRIG_RST = 16'h0000;
   localparam logic [15:0] PTS_RISE_RST = 16'h0000;
   localparam logic [15:0] PTS_FALL_RST = 16'h0000;
   localparam logic [15:0] PTS_RET_RST = 16'h0000;
   localparam logic [31:0] PTS_FWD_RST = 32'h7FFFFFFF;
   localparam logic [31:0] PTS_REV_RST = 32'h80000001;
   localparam logic [31:0] PTS_POS_FORBID = 32'h80000000;
   typedef enum logic [1:0] {
      PTS_PH_IDLE = 2'b00,
      PTS_PH_ISSUE = 2'b01,
      PTS_PH_MOVE = 2'b10,
      PTS_PH_REACH = 2'b11
   } pts_phase_type;
endpackage

// ### tb/pts_motion_model.sv
// Motion side model that answers path, homing and stop starts
`timescale 1ns/1ps
module pts_motion_model #(
   parameter int ISSUE_DLY = 6,
   parameter int MOVE_DLY = 6
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic start_i,
   output logic cmd_issued_o,
   output logic motion_done_o,
   output logic target_reached_o
);
   int cnt;
   int ph;
   always_ff @(posedge mclk_i)
   begin
      cmd_issued_o <= 1'b0;
      if (srst_i)
      begin
         ph <= 0;
         cnt <= 0;
         motion_done_o <= 1'b0;
         target_reached_o <= 1'b0;
      end
      else if (start_i)
      begin
         ph <= 1;
         cnt <= ISSUE_DLY;
         motion_done_o <= 1'b0;
         target_reached_o <= 1'b0;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
      else if (ph == 1)
      begin
         cmd_issued_o <= 1'b1;
         ph <= 2;
         cnt <= MOVE_DLY;
      end
      else if (ph == 2)
      begin
         motion_done_o <= 1'b1;
         target_reached_o <= 1'b1;
         ph <= 0;
      end
   end
endmodule

// ### tb/pts_path_trigger_tb_top.sv
// Testbench for the path trigger and soft limit block
`timescale 1ns/1ps
module pts_path_trigger_tb_top;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic par_wr_i = 1'b0;
   logic par_rd_i = 1'b0;
   logic [6:0] par_addr_i = 7'h00;
   logic [31:0] par_wdata_i = 32'h00000000;
   logic [31:0] par_rdata_o;
   logic par_ack_o;
   logic par_err_o;
   logic [3:0] event_input_i = 4'h0;
   logic cmd_issued_i;
   logic motion_done_i;
   logic target_reached_output_i;
   logic path_mode_i = 1'b0;
   logic [31:0] feedback_pos_i = 32'h00000000;
   logic alarm_clear_i = 1'b0;
   logic home_start_o;
   logic path_start_o;
   logic [5:0] path_num_o;
   logic stop_o;
   logic path1_volatile_o;
   logic path2_volatile_o;
   logic forward_overtravel_alarm_o;
   logic reverse_overtravel_alarm_o;
   logic [2:0] starts;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] cmds [4] = '{32'h0, 32'h5, 32'h3F, 32'h3E8};
   logic [2:0] kinds [4] = '{3'h4, 3'h2, 3'h2, 3'h1};
   logic [31:0] ret_w [3] = '{32'hFFFF, 32'h0010, 32'h0001};
   logic [31:0] ret_r [3] = '{32'h0011, 32'h0010, 32'h0001};

   pts_path_trigger i_dut (.mclk_i, .srst_i, .par_wr_i, .par_rd_i, .par_addr_i, .par_wdata_i,
      .par_rdata_o, .par_ack_o, .par_err_o, .event_input_i, .cmd_issued_i, .motion_done_i,
      .target_reached_output_i, .path_mode_i, .feedback_pos_i, .alarm_clear_i, .home_start_o,
      .path_start_o, .path_num_o, .stop_o, .path1_volatile_o, .path2_volatile_o,
      .forward_overtravel_alarm_o, .reverse_overtravel_alarm_o);

   pts_motion_model i_motion (.mclk_i(mclk_i), .srst_i(srst_i),
      .start_i(home_start_o | path_start_o | stop_o), .cmd_issued_o(cmd_issued_i),
      .motion_done_o(motion_done_i), .target_reached_o(target_reached_output_i));

   initial
   begin
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic stop_test;
      $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic e);
      @(posedge mclk_i);
      par_wr_i <= 1'b1;
      par_addr_i <= a;
      par_wdata_i <= d;
      @(posedge mclk_i);
      par_wr_i <= 1'b0;
      #1;
      starts = {home_start_o, path_start_o, stop_o};
      chk({31'h0, par_ack_o}, 32'h1, "ack");
      chk({31'h0, par_err_o}, {31'h0, e}, "err");
   endtask

   task automatic rd(input logic [6:0] a, input logic [31:0] x);
      @(posedge mclk_i);
      par_rd_i <= 1'b1;
      par_addr_i <= a;
      @(posedge mclk_i);
      par_rd_i <= 1'b0;
      #1;
      chk(par_rdata_o, x, "rdata");
   endtask

   task automatic wait_flag(input logic sel);
      int i;
      i = 0;
      while (((sel ? motion_done_i : cmd_issued_i) !== 1'b1) && i < 40)
      begin
         @(posedge mclk_i);
         #1;
         i++;
      end
      chk(32'(i < 40), 32'h1, "motion wait");
   endtask

   task automatic ev(input int k, input logic v, input int n, input logic [5:0] num);
      int cnt;
      cnt = 0;
      @(posedge mclk_i);
      event_input_i[k] <= v;
      repeat (8)
      begin
         @(posedge mclk_i);
         #1;
         if (path_start_o === 1'b1)
            cnt++;
      end
      chk(32'(cnt), 32'(n), "launch count");
      if (n > 0)
         chk({26'h0, path_num_o}, {26'h0, num}, "event path");
   endtask

   task automatic pos(input logic [31:0] p, input logic f, input logic r);
      @(posedge mclk_i);
      feedback_pos_i <= p;
      repeat (2) @(posedge mclk_i);
      #1;
      chk({31'h0, forward_overtravel_alarm_o}, {31'h0, f}, "fwd alarm");
      chk({31'h0, reverse_overtravel_alarm_o}, {31'h0, r}, "rev alarm");
   endtask

   initial
   begin
      repeat (12) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(pts_pkg::PTS_IDX_TRIG, 32'h0);
      rd(pts_pkg::PTS_IDX_RISE, 32'h0);
      rd(pts_pkg::PTS_IDX_FALL, 32'h0);
      rd(pts_pkg::PTS_IDX_RET, 32'h0);
      rd(pts_pkg::PTS_IDX_FWD, 32'h7FFFFFFF);
      rd(pts_pkg::PTS_IDX_REV, 32'h80000001);
      wr(7'h58, 32'h1, 1'b1);
      rd(7'h58, 32'h0);
      $display("Test reset values done");
      foreach (cmds[i])
      begin
         wr(pts_pkg::PTS_IDX_TRIG, cmds[i], 1'b0);
         chk({29'h0, starts}, {29'h0, kinds[i]}, "start kind");
         if (kinds[i] == 3'h2)
            chk({26'h0, path_num_o}, cmds[i], "path num");
         rd(pts_pkg::PTS_IDX_TRIG, cmds[i]);
         wait_flag(1'b0);
         rd(pts_pkg::PTS_IDX_TRIG, cmds[i] + 32'h2710);
         wait_flag(1'b1);
         rd(pts_pkg::PTS_IDX_TRIG, cmds[i] + 32'h4E20);
      end
      $display("Test trigger codes done");
      wr(pts_pkg::PTS_IDX_TRIG, 32'h40, 1'b1);
      chk({29'h0, starts}, 32'h0, "no start");
      wr(pts_pkg::PTS_IDX_TRIG, 32'h270F, 1'b1);
      wr(pts_pkg::PTS_IDX_TRIG, 32'h10005, 1'b1);
      rd(pts_pkg::PTS_IDX_TRIG, 32'h3E8 + 32'h4E20);
      $display("Test refused triggers done");
      wr(pts_pkg::PTS_IDX_RISE, 32'h00E1, 1'b1);
      wr(pts_pkg::PTS_IDX_RISE, 32'h0D01, 1'b0);
      wr(pts_pkg::PTS_IDX_FALL, 32'h2000, 1'b0);
      rd(pts_pkg::PTS_IDX_RISE, 32'h0D01);
      ev(0, 1'b1, 1, 6'h33);
      ev(1, 1'b1, 0, 6'h00);
      ev(2, 1'b1, 1, 6'h3F);
      ev(3, 1'b1, 0, 6'h00);
      ev(3, 1'b0, 1, 6'h34);
      ev(0, 1'b0, 0, 6'h00);
      $display("Test events done");
      foreach (ret_w[i])
      begin
         wr(pts_pkg::PTS_IDX_RET, ret_w[i], 1'b0);
         rd(pts_pkg::PTS_IDX_RET, ret_r[i]);
         chk({30'h0, path2_volatile_o, path1_volatile_o},
            {30'h0, ret_r[i][4], ret_r[i][0]}, "volatile");
      end
      $display("Test retention done");
      wr(pts_pkg::PTS_IDX_FWD, 32'h000003E8, 1'b0);
      wr(pts_pkg::PTS_IDX_REV, 32'hFFFFFC18, 1'b0);
      wr(pts_pkg::PTS_IDX_FWD, 32'h80000000, 1'b1);
      rd(pts_pkg::PTS_IDX_FWD, 32'h000003E8);
      pos(32'h000007D0, 1'b0, 1'b0);
      @(posedge mclk_i);
      path_mode_i <= 1'b1;
      pos(32'h000007D0, 1'b0, 1'b0);
      pos(32'h000007D1, 1'b1, 1'b0);
      @(posedge mclk_i);
      alarm_clear_i <= 1'b1;
      @(posedge mclk_i);
      alarm_clear_i <= 1'b0;
      pos(32'h00000000, 1'b0, 1'b0);
      pos(32'hFFFFFC17, 1'b0, 1'b1);
      $display("Test soft limits done");
      stop_test();
   end
endmodule
